// ==== dpk_core.sv ====
// dds core control: tuning, phase offset, accumulator clears and shaped keying
//
// How it works
// RULE1 - stored tuning word feeds accumulator, changed only on update strobe
// RULE2 - fourteen-bit phase offset added to accumulator before amplitude stage
// RULE3 - continuous-clear bit holds accumulator at zero while set
// RULE4 - auto-clear bit clears accumulator once on each update strobe
// RULE5 - keying disabled bypasses scaling; disabled after reset
// RULE6 - internal bit picks auto or manual keying; ignored when disabled
// RULE7 - auto scale from counter stepped at programmed ramp rate
// RULE8 - auto counter rises with keying pin high, falls when low
// RULE9 - scale is unsigned multiplier; zero gives zero output
// RULE10 - step field codes 0..3 give steps 1, 2, 4, 8
// RULE11 - auto scale never exceeds amplitude scale register value
// RULE12 - rate timer reloads at count one and ticks scale counter
// RULE13 - keying pin change reloads rate timer
// RULE14 - load-timer bit makes update strobe reload rate timer
// RULE15 - entering auto keying loads rate timer
// RULE16 - manual keying applies amplitude register, committed by update
// RULE17 - update pin sampled on sync clock rising edges; host keeps low gap
// RULE18 - sync clock is system clock divided by four, driven out
// RULE19 - phase offset word is fraction of full turn over two to fourteen
// RULE20 - auto counter saturates at zero and at limit, never wraps
//
// Decided for this implementation: the address map and strobed register access.
`default_nettype none
`include "dpk_consts.svh"
module dpk_core
  import dpk_pkg::*;
#(
  parameter int FTW_W   = 32,
  parameter int PHASE_W = 14,
  parameter int SCALE_W = 14,
  parameter int RATE_W  = 8,
  parameter int CORE_W  = 14
) (
  input  wire logic               CLOCK_I,
  input  wire logic               RESET_I,
  input  wire logic [3:0]         ADDR_I,
  input  wire logic [31:0]        WDATA_I,
  input  wire logic               WR_I,
  input  wire logic               RD_I,
  output logic      [31:0]        RDATA_O,
  input  wire logic               UPDATE_I,
  input  wire logic               KEY_I,
  output logic                    SYNC_CLK_O,
  input  wire logic [CORE_W-1:0]  CORE_AMP_I,
  output logic      [PHASE_W-1:0] PHASE_O,
  output logic      [CORE_W-1:0]  DAC_O
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // status word and step field leave fourteen bits for the scale
  if (SCALE_W > 14 || SCALE_W < 4) begin : g_bad_scale
    $error("dpk_core: scale width must be 4 to 14");
  end
  if (FTW_W > 32 || PHASE_W > FTW_W || PHASE_W < 1) begin : g_bad_phase
    $error("dpk_core: tuning or phase width out of range");
  end
  if (RATE_W > 16 || RATE_W < 1) begin : g_bad_rate
    $error("dpk_core: ramp rate width out of range");
  end
  if (CORE_W < 1) begin : g_bad_core
    $error("dpk_core: core sample width out of range");
  end

  // ----------------------------------------------------------------
  // pin synchronisers and sync clock divider
  // ----------------------------------------------------------------
  logic       upd_s1_reg, upd_s2_reg, key_s1_reg, key_s2_reg;
  logic [1:0] div_reg, div_next;
  logic       upd_smp_reg, upd_smp_next;
  logic       sync_rise;
  logic       update;

  always_comb begin
    // RULE18 divide by four
    div_next = div_reg + 2'(1);
    sync_rise = (div_reg == 2'(`DPK_SYNC_DIV / 2 - 1));
    // RULE17 sample on sync edge
    upd_smp_next = sync_rise ? upd_s2_reg : upd_smp_reg;
  end

  // the sampler holds the pin level seen at the last sync clock rise
  // single pulse on a sampled rising edge of the update pin
  assign update = sync_rise && upd_s2_reg && !upd_smp_reg;

  // two flops on each pin before any logic reads them
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      upd_s1_reg <= 1'b0;
      upd_s2_reg <= 1'b0;
      key_s1_reg <= 1'b0;
      key_s2_reg <= 1'b0;
    end else begin
      upd_s1_reg <= UPDATE_I;
      upd_s2_reg <= upd_s1_reg;
      key_s1_reg <= KEY_I;
      key_s2_reg <= key_s1_reg;
    end
  end

  // the host times its pins from the divider, so it never stops
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      div_reg     <= '0;
      upd_smp_reg <= 1'b0;
    end else begin
      div_reg     <= div_next;
      upd_smp_reg <= upd_smp_next;
    end
  end

  // ----------------------------------------------------------------
  // register bank: buffered words and committed words
  // ----------------------------------------------------------------
  logic [31:0]        ctrl_buf_reg, ctrl_buf_next, ctrl_reg, ctrl_next;
  logic [FTW_W-1:0]   ftw_buf_reg, ftw_buf_next, ftw_reg, ftw_next;
  logic [PHASE_W-1:0] pho_buf_reg, pho_buf_next, pho_reg, pho_next;
  logic [15:0]        amp_buf_reg, amp_buf_next, amp_reg, amp_next;
  logic [RATE_W-1:0]  rate_buf_reg, rate_buf_next, rate_reg, rate_next;
  logic [31:0]        rdata_next;
  logic [FTW_W-1:0]   acc_reg, acc_next;
  dpk_key_mode_t      key_mode;
  logic [SCALE_W-1:0] scale_reg, scale_next;
  logic [31:0]        status_word;

  // status word: mode in bits 17:16, applied scale in bits 13:0
  always_comb begin
    status_word        = '0;
    status_word[17:16] = 2'(key_mode);
    status_word[13:0]  = 14'(scale_reg);
  end

  always_comb begin
    ctrl_buf_next = ctrl_buf_reg;
    ftw_buf_next  = ftw_buf_reg;
    pho_buf_next  = pho_buf_reg;
    amp_buf_next  = amp_buf_reg;
    rate_buf_next = rate_buf_reg;
    if (WR_I) begin
      unique case (ADDR_I)
        `DPK_ADDR_CTRL:  ctrl_buf_next = WDATA_I;
        `DPK_ADDR_FTW:   ftw_buf_next  = WDATA_I[FTW_W-1:0];
        `DPK_ADDR_PHASE: pho_buf_next  = WDATA_I[PHASE_W-1:0];
        `DPK_ADDR_AMP:   amp_buf_next  = WDATA_I[15:0];
        `DPK_ADDR_RATE:  rate_buf_next = WDATA_I[RATE_W-1:0];
        default: ;
      endcase
    end
    // committed copies move only on an update, so a half-written
    // set of words never reaches the core
    // RULE1 RULE16 commit only on update
    ctrl_next = update ? ctrl_buf_reg : ctrl_reg;
    ftw_next  = update ? ftw_buf_reg  : ftw_reg;
    pho_next  = update ? pho_buf_reg  : pho_reg;
    amp_next  = update ? amp_buf_reg  : amp_reg;
    rate_next = update ? rate_buf_reg : rate_reg;
    rdata_next = '0;
    if (RD_I) begin
      unique case (ADDR_I)
        `DPK_ADDR_CTRL:   rdata_next = ctrl_buf_reg;
        `DPK_ADDR_FTW:    rdata_next = 32'(ftw_buf_reg);
        `DPK_ADDR_PHASE:  rdata_next = 32'(pho_buf_reg);
        `DPK_ADDR_AMP:    rdata_next = 32'(amp_buf_reg);
        `DPK_ADDR_RATE:   rdata_next = 32'(rate_buf_reg);
        `DPK_ADDR_STATUS: rdata_next = status_word;
        `DPK_ADDR_PHACC:  rdata_next = 32'(acc_reg);
        default:          rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      // RULE5 keying disabled at reset
      ctrl_buf_reg <= `DPK_CTRL_RESET;
      ctrl_reg     <= `DPK_CTRL_RESET;
      ftw_buf_reg  <= '0;
      ftw_reg      <= '0;
      pho_buf_reg  <= '0;
      pho_reg      <= '0;
      amp_buf_reg  <= '0;
      amp_reg      <= '0;
      rate_buf_reg <= '0;
      rate_reg     <= '0;
      RDATA_O      <= '0;
    end else begin
      ctrl_buf_reg <= ctrl_buf_next;
      ctrl_reg     <= ctrl_next;
      ftw_buf_reg  <= ftw_buf_next;
      ftw_reg      <= ftw_next;
      pho_buf_reg  <= pho_buf_next;
      pho_reg      <= pho_next;
      amp_buf_reg  <= amp_buf_next;
      amp_reg      <= amp_next;
      rate_buf_reg <= rate_buf_next;
      rate_reg     <= rate_next;
      RDATA_O      <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // phase accumulator and offset
  // ----------------------------------------------------------------
  logic [PHASE_W-1:0] phase_next, phase_reg;

  always_comb begin
    // a clear below overrides the tuning step for that cycle
    acc_next = acc_reg + ftw_reg;
    // RULE3 continuous clear
    if (ctrl_reg[`DPK_BIT_CONT_CLR]) begin
      acc_next = '0;
    // RULE4 clear on each update
    end else if (update && ctrl_buf_reg[`DPK_BIT_AUTO_CLR]) begin
      acc_next = '0;
    end
    // RULE2 RULE19 offset in units of a turn over 2^PHASE_W
    phase_next = acc_reg[FTW_W-1 -: PHASE_W] + pho_reg;
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      acc_reg   <= '0;
      phase_reg <= '0;
    end else begin
      acc_reg   <= acc_next;
      phase_reg <= phase_next;
    end
  end

  assign PHASE_O = phase_reg;

  // ----------------------------------------------------------------
  // shaped keying
  // ----------------------------------------------------------------
  logic [SCALE_W-1:0]     auto_scale;
  logic [SCALE_W+CORE_W-1:0] prod;
  logic [CORE_W-1:0]      dac_reg, dac_next;
  logic [SCALE_W-1:0]     amp_limit;
  logic [1:0]             step_code;
  logic                   auto_active;
  logic                   force_load;

  assign amp_limit = amp_reg[SCALE_W-1:0];
  // RULE10 step field sits above the scale value
  assign step_code = amp_reg[`DPK_AMP_STEP_HI:`DPK_AMP_STEP_LO];
  // leaving auto mode zeroes the ramp, so each entry starts from silence
  assign auto_active = (key_mode == DPK_KEY_AUTO);
  // RULE14 update reloads timer, load bit taken from the word being committed
  assign force_load = update && ctrl_buf_reg[`DPK_BIT_LOAD_TMR];

  always_comb begin
    // RULE5 RULE6 mode select
    if (!ctrl_reg[`DPK_BIT_KEY_EN]) begin
      key_mode = DPK_KEY_BYPASS;
    end else if (ctrl_reg[`DPK_BIT_KEY_INT]) begin
      key_mode = DPK_KEY_AUTO;
    end else begin
      key_mode = DPK_KEY_MANUAL;
    end
  end

  dpk_ramp #(
    .SCALE_W (SCALE_W),
    .RATE_W  (RATE_W)
  ) u_ramp (
    .clk_i        (CLOCK_I),
    .rst_i        (RESET_I),
    .active_i     (auto_active),
    .key_i        (key_s2_reg),
    .force_load_i (force_load),
    .rate_i       (rate_reg),
    .step_code_i  (step_code),
    .limit_i      (amp_limit),
    .scale_o      (auto_scale)
  );

  always_comb begin
    unique case (key_mode)
      DPK_KEY_AUTO:   scale_next = auto_scale;
      // RULE16 manual uses register
      DPK_KEY_MANUAL: scale_next = amp_limit;
      default:        scale_next = SCALE_W'(`DPK_SCALE_FULL);
    endcase
    // RULE9 unsigned scale, full code gives 16383/16384 of the core sample
    prod = {{SCALE_W{1'b0}}, CORE_AMP_I} * {{CORE_W{1'b0}}, scale_reg};
    // bypass skips the multiplier so the core sample passes untouched
    if (key_mode == DPK_KEY_BYPASS) begin
      dac_next = CORE_AMP_I;
    end else begin
      dac_next = prod[SCALE_W+CORE_W-1 -: CORE_W];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      scale_reg <= '0;
      dac_reg   <= '0;
    end else begin
      scale_reg <= scale_next;
      dac_reg   <= dac_next;
    end
  end

  assign DAC_O = dac_reg;
  // RULE18 sync clock out
  assign SYNC_CLK_O = div_reg[1];
endmodule // dpk_core
`default_nettype wire

// ==== dpk_consts.svh ====
// constants for the dds phase and amplitude keying block
`ifndef DPK_CONSTS_SVH
`define DPK_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DPK_ADDR_CTRL     4'h0
`define DPK_ADDR_FTW      4'h1
`define DPK_ADDR_PHASE    4'h2
`define DPK_ADDR_AMP      4'h3
`define DPK_ADDR_RATE     4'h4
`define DPK_ADDR_STATUS   4'h5
`define DPK_ADDR_PHACC    4'h6

// ----------------------------------------------------------------
// control word bit positions
// ----------------------------------------------------------------
`define DPK_BIT_CONT_CLR  10
`define DPK_BIT_AUTO_CLR  13
`define DPK_BIT_KEY_INT   24
`define DPK_BIT_KEY_EN    25
`define DPK_BIT_LOAD_TMR  26

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define DPK_AMP_STEP_HI   15
`define DPK_AMP_STEP_LO   14
`define DPK_CTRL_RESET    32'h0000_0000
`define DPK_SYNC_DIV      4
`define DPK_SCALE_FULL    14'h3FFF

`endif

// ==== dpk_pkg.sv ====
// types for the dds phase and amplitude keying block
`default_nettype none
package dpk_pkg;
  typedef enum logic [1:0] {
    DPK_KEY_BYPASS,
    DPK_KEY_MANUAL,
    DPK_KEY_AUTO
  } dpk_key_mode_t;
endpackage
`default_nettype wire

// ==== dpk_ramp.sv ====
// automatic keying ramp: rate timer and saturating scale counter
`default_nettype none
`include "dpk_consts.svh"
module dpk_ramp
  import dpk_pkg::*;
#(
  parameter int SCALE_W = 14,
  parameter int RATE_W  = 8
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               active_i,
  input  wire logic               key_i,
  input  wire logic               force_load_i,
  input  wire logic [RATE_W-1:0]  rate_i,
  input  wire logic [1:0]         step_code_i,
  input  wire logic [SCALE_W-1:0] limit_i,
  output logic      [SCALE_W-1:0] scale_o
);
  // the largest step of eight needs four scale bits
  if (SCALE_W < 4 || RATE_W < 1) begin : g_bad_width
    $error("dpk_ramp: widths too small");
  end

  logic [RATE_W-1:0]  timer_reg, timer_next;
  logic [SCALE_W-1:0] scale_reg, scale_next;
  logic               key_d_reg, key_d_next;
  logic               act_d_reg, act_d_next;
  logic [SCALE_W:0]   step;
  logic [SCALE_W:0]   sum;
  logic               tick;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    key_d_next = key_i;
    act_d_next = active_i;
    // RULE10 step size decode
    step = (SCALE_W+1)'(1) << step_code_i;
    // RULE12 tick at count of one or zero
    tick = active_i && (timer_reg <= RATE_W'(1));
    timer_next = timer_reg;
    if (active_i) begin
      // RULE13 RULE14 RULE15 forced reloads
      if ((key_i != key_d_reg) || force_load_i || !act_d_reg) begin
        timer_next = rate_i;
      // RULE12 reload at one
      end else if (tick) begin
        timer_next = rate_i;
      end else begin
        timer_next = timer_reg - RATE_W'(1);
      end
    end
    scale_next = scale_reg;
    sum = {1'b0, scale_reg} + step;
    if (!active_i) begin
      scale_next = '0;
    end else if (tick) begin
      // RULE8 RULE11 RULE20 up or down, saturated
      if (key_i) begin
        if (sum >= {1'b0, limit_i}) begin
          scale_next = limit_i;
        end else begin
          scale_next = sum[SCALE_W-1:0];
        end
      end else if ({1'b0, scale_reg} <= step) begin
        scale_next = '0;
      end else begin
        scale_next = scale_reg - step[SCALE_W-1:0];
      end
    end else if (scale_reg > limit_i) begin
      scale_next = limit_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_reg <= '0;
      scale_reg <= '0;
      key_d_reg <= 1'b0;
      act_d_reg <= 1'b0;
    end else begin
      timer_reg <= timer_next;
      scale_reg <= scale_next;
      key_d_reg <= key_d_next;
      act_d_reg <= act_d_next;
    end
  end

  // RULE7 counter drives scale
  assign scale_o = scale_reg;
endmodule // dpk_ramp
`default_nettype wire

// ==== dpk_core_checker.sv ====
// port checker for the dds keying block
`default_nettype none
module dpk_core_checker #(
  parameter int PHASE_W = 14,
  parameter int CORE_W  = 14
) (
  input wire logic               CLOCK_I,
  input wire logic               RESET_I,
  input wire logic [3:0]         ADDR_I,
  input wire logic               RD_I,
  input wire logic [31:0]        RDATA_O,
  input wire logic               SYNC_CLK_O,
  input wire logic [CORE_W-1:0]  CORE_AMP_I,
  input wire logic [PHASE_W-1:0] PHASE_O,
  input wire logic [CORE_W-1:0]  DAC_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  sync_divide_a: assert property (
    $rose(SYNC_CLK_O) |=> SYNC_CLK_O ##1 (!SYNC_CLK_O) [*2] ##1 SYNC_CLK_O)
    else $error("sync clock is not a divide by four");
  reset_quiet_a: assert property (disable iff (1'h0)
    RESET_I |=> DAC_O == '0 && PHASE_O == '0 && RDATA_O == 32'h0 && !SYNC_CLK_O)
    else $error("outputs not quiet after reset");
  read_idle_a: assert property (
    !$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data without a read");
  dac_bound_a: assert property (
    $stable(CORE_AMP_I) && CORE_AMP_I == $past(CORE_AMP_I, 2) |-> DAC_O <= CORE_AMP_I)
    else $error("scaled output above core sample");
  unmapped_read_a: assert property (
    RD_I && ADDR_I > 4'h6 |=> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  status_pad_a: assert property (
    RD_I && ADDR_I == 4'h5 |=> RDATA_O[31:18] == 14'h0 && RDATA_O[15:14] == 2'h0
      && RDATA_O[17:16] != 2'h3)
    else $error("status layout broken");
  rate_width_a: assert property (
    RD_I && ADDR_I == 4'h4 |=> RDATA_O[31:8] == 24'h0)
    else $error("ramp rate wider than eight bits");
  offset_width_a: assert property (
    RD_I && ADDR_I == 4'h2 |=> RDATA_O[31:14] == 18'h0)
    else $error("phase offset wider than fourteen bits");
endmodule // dpk_core_checker

bind dpk_core dpk_core_checker #(.PHASE_W(PHASE_W), .CORE_W(CORE_W)) i_chk (
  .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .SYNC_CLK_O(SYNC_CLK_O), .CORE_AMP_I(CORE_AMP_I),
  .PHASE_O(PHASE_O), .DAC_O(DAC_O));
`default_nettype wire

// ==== dpk_host.sv ====
// host model driving the update and keying pins on the sync clock
`default_nettype none
module dpk_host (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sync_i,
  input  wire logic req_i,
  input  wire logic key_req_i,
  output logic      update_o,
  output logic      key_o,
  output logic      busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sync_q;
  logic       pend;
  logic [1:0] step;
  assign busy_o = pend || step != 2'h0;
  always @(posedge clk_i) begin
    sync_q <= sync_i;
    if (req_i) begin
      pend <= 1'h1;
    end
    if (rst_i) begin
      pend     <= 1'h0;
      step     <= 2'h0;
      update_o <= 1'h0;
      key_o    <= 1'h0;
    end else if (sync_i && !sync_q) begin
      key_o <= key_req_i;
      // low gap of two sync cycles
      if (step == 2'h1) begin
        update_o <= 1'h0;
        step     <= 2'h2;
      end else if (step == 2'h2) begin
        step <= 2'h0;
      end else if (pend) begin
        update_o <= 1'h1;
        pend     <= 1'h0;
        step     <= 2'h1;
      end
    end
  end
endmodule // dpk_host
`default_nettype wire

// ==== testbench.sv ====
// register level testbench for the dds keying block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [31:0] rdata;
  logic        upd;
  logic        key;
  logic        sync_clk;
  logic [13:0] core_amp = 14'h1234;
  logic [13:0] phase;
  logic [13:0] dac;
  logic        req = 1'h0;
  logic        key_req = 1'h0;
  logic        busy;
  int          n_fail = 0;
  int          checks = 0;
  logic [31:0] v;
  logic [31:0] a0;
  logic [13:0] amp_t[3] = '{14'h2000, 14'h3FFF, 14'h0000};
  logic [31:0] dac_t[3] = '{32'h091A, 32'h1233, 32'h0};

  always #25 clk = ~clk;

  dpk_core i_dut (.CLOCK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .UPDATE_I(upd), .KEY_I(key),
    .SYNC_CLK_O(sync_clk), .CORE_AMP_I(core_amp), .PHASE_O(phase), .DAC_O(dac));
  dpk_host i_host (.clk_i(clk), .rst_i(rst), .sync_i(sync_clk), .req_i(req),
    .key_req_i(key_req), .update_o(upd), .key_o(key), .busy_o(busy));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd   <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdata;
  endtask
  task automatic expect_reg(input string what, input logic [3:0] a, input logic [31:0] exp);
    rd_reg(a);
    check(what, exp, v);
  endtask
  task automatic update();
    @(posedge clk);
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      #1;
      if (!busy) break;
    end
    check("update done", 32'h0, 32'(busy));
  endtask
  task automatic poll_scale(input string what, input logic [13:0] exp);
    for (int i = 0; i < 60; i++) begin
      rd_reg(4'h5);
      if (v[13:0] === exp) break;
    end
    check(what, 32'(exp), 32'(v[13:0]));
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    expect_reg("control", 4'h0, 32'h0);
    check("bypass dac", 32'h1234, 32'(dac));
    wr_reg(4'h1, 32'h0100_0000);
    wr_reg(4'h2, 32'h0000_2ABC);
    wr_reg(4'h4, 32'h0000_0001);
    wr_reg(4'h7, 32'hFFFF_FFFF);
    expect_reg("tuning", 4'h1, 32'h0100_0000);
    expect_reg("offset", 4'h2, 32'h0000_2ABC);
    expect_reg("unmapped", 4'h7, 32'h0);
    expect_reg("acc before update", 4'h6, 32'h0);
    update();
    rd_reg(4'h6);
    a0 = v;
    rd_reg(4'h6);
    check("acc step", 32'h0200_0000, v - a0);
    $display("test tuning done");
    wr_reg(4'h0, 32'h0000_0400);
    update();
    expect_reg("acc held", 4'h6, 32'h0);
    check("phase offset", 32'h2ABC, 32'(phase));
    wr_reg(4'h0, 32'h0);
    update();
    rd_reg(4'h6);
    a0 = v;
    rd_reg(4'h6);
    check("acc resumes", 32'h0200_0000, v - a0);
    $display("test clear done");
    wr_reg(4'h1, 32'h0000_0100);
    wr_reg(4'h0, 32'h0000_2000);
    for (int n = 0; n < 2; n++) begin
      repeat (30) rd_reg(4'h6);
      update();
      rd_reg(4'h6);
      check("auto clear", 32'h1, 32'(v < 32'h1400));
    end
    $display("test auto clear done");
    wr_reg(4'h0, 32'h0200_0000);
    for (int n = 0; n < 3; n++) begin
      wr_reg(4'h3, {18'h0, amp_t[n]});
      update();
      wr_reg(4'h3, 32'h0000_1111);
      rd_reg(4'h5);
      check("manual status", {14'h0, 2'h1, 2'h0, amp_t[n]}, v);
      check("manual dac", dac_t[n], 32'(dac));
    end
    $display("test manual done");
    // a rate of four lets every scale step stand for two reads
    wr_reg(4'h4, 32'h0000_0004);
    for (int c = 0; c < 4; c++) begin
      key_req <= 1'h0;
      wr_reg(4'h0, 32'h0);
      update();
      wr_reg(4'h3, {16'h0, 2'(c), 14'h3FFF});
      wr_reg(4'h0, 32'h0300_0000);
      update();
      key_req <= 1'h1;
      poll_scale("ramp start", 14'(1 << c));
      a0 = v;
      repeat (2) rd_reg(4'h5);
      check("step size", 32'(1 << c), v - a0);
      check("auto mode", 32'h2, 32'(v[17:16]));
    end
    key_req <= 1'h0;
    wr_reg(4'h0, 32'h0);
    update();
    wr_reg(4'h3, 32'h0000_C045);
    wr_reg(4'h0, 32'h0300_0000);
    update();
    key_req <= 1'h1;
    poll_scale("ramp limit", 14'h0045);
    repeat (8) rd_reg(4'h5);
    check("limit holds", 32'h0045, 32'(v[13:0]));
    check("auto dac", (32'h1234 * 32'h0045) >> 14, 32'(dac));
    key_req <= 1'h0;
    poll_scale("ramp down", 14'h0000);
    repeat (8) rd_reg(4'h5);
    check("zero holds", 32'h0, 32'(v[13:0]));
    $display("test auto keying done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
